// ### src/ipv6_fwd.sv
// Purpose: ipv6 unicast forwarding decision and nd control
// Assumes: headers parsed upstream, one packet at a time
// Notes: one held packet while resolution is pending
`timescale 1ns/100ps
module ipv6_fwd #(
    parameter int RESOLVE_CYCLES = fwd_pkg::RESOLVE_CYCLES, // wait for advert
    parameter int RA_CYCLES = fwd_pkg::RA_CYCLES, // advert period
    parameter int CACHE_ENTRIES = fwd_pkg::CACHE_ENTRIES // cache size
) (
    input wire logic mclk, // 20 MHz clock
    input wire logic reset, // sync, active high
    input wire logic [127:0] opIp, // operator side address
    input wire logic [127:0] custIp, // customer side address
    input wire logic [63:0] opPrefix, // operator /64
    input wire logic [63:0] custPrefix, // customer /64
    input wire logic [47:0] opMac, // operator side mac
    input wire logic [47:0] custMac, // customer side mac
    input wire logic pktValid, // header offered
    output logic pktReady, // header taken
    input wire logic pktPort, // receiving interface
    input wire logic [127:0] pktSrc, // source address
    input wire logic [127:0] pktDst, // destination address
    input wire logic [7:0] pktHop, // hop limit
    input wire logic [7:0] pktNext, // next header
    input wire logic [7:0] pktIcmp, // icmpv6 type
    input wire logic pktL2Mcast, // link layer multicast
    input wire logic pktCongested, // queue overflow drop
    input wire logic naValid, // parsed advert strobe
    input wire logic [127:0] naTarget, // advertised address
    input wire logic [47:0] naMac, // advertised mac
    input wire logic raValid, // parsed router advert
    input wire logic raPort, // advert interface
    input wire logic [127:0] raRouter, // advert source
    input wire logic raPrefixValid, // advert has prefix
    input wire logic [63:0] raPrefix, // on-link prefix
    output logic resValid, // decision pulse
    output logic [1:0] resAction, // local, forward, drop
    output logic resPort, // egress interface
    output logic [47:0] resDstMac, // rebuilt dest mac
    output logic [47:0] resSrcMac, // rebuilt source mac
    output logic [7:0] resHop, // hop limit to send
    output logic errValid, // icmpv6 error request
    output logic [7:0] errType, // error type
    output logic [7:0] errCode, // error code
    output logic errPort, // error egress
    output logic ndValid, // nd message request
    output logic [7:0] ndType, // rs, ra or ns
    output logic ndPort, // nd egress
    output logic [127:0] ndTarget // target or group
);
    localparam int TW = fwd_pkg::TIMER_W;
    // counts must fit the timers
    if (RESOLVE_CYCLES < 2 || RESOLVE_CYCLES >= (1 << TW) ||
        RA_CYCLES < 2 || RA_CYCLES >= (1 << TW)) begin : g_bad
        $error("ipv6_fwd: timer counts out of range");
    end
    localparam logic [TW-1:0] RESOLVE_LAST = TW'(RESOLVE_CYCLES - 1);
    localparam logic [TW-1:0] RA_LAST = TW'(RA_CYCLES - 1);

    typedef struct packed {
        fwd_pkg::state_e state; // engine state
        logic port; // receiving interface
        logic [127:0] src; // held source
        logic [127:0] dst; // held destination
        logic [7:0] hop; // held hop limit
        logic [7:0] nxt; // held next header
        logic [7:0] icmp; // held icmp type
        logic l2Mcast; // held l2 multicast flag
        logic congested; // held congestion flag
        logic [127:0] nh; // chosen next hop
        logic nhPort; // next hop interface
        logic [TW-1:0] timer; // resolution wait
        logic [TW-1:0] raTimer; // advert period
        logic rsDone; // solicitation sent
        logic drValid; // default router known
        logic [127:0] drAddr; // default router
        logic lpValid; // learned prefix known
        logic [63:0] lpPrefix; // learned prefix
        logic resValid;
        logic [1:0] resAction;
        logic resPort;
        logic [47:0] resDstMac;
        logic [47:0] resSrcMac;
        logic [7:0] resHop;
        logic errValid;
        logic [7:0] errType;
        logic [7:0] errCode;
        logic errPort;
        logic ndValid;
        logic [7:0] ndType;
        logic ndPort;
        logic [127:0] ndTarget;
    } fwd_s;
    fwd_s st;
    fwd_s next_st;

    logic cacheHit; // next hop resolved
    logic [47:0] cacheMac; // resolved mac
    logic isMc; // ipv6 multicast dest
    logic isLlMc; // link local multicast
    logic isOwn; // own address
    logic isIcmpErr; // packet is an icmp error
    logic srcOk; // source names one node
    logic errOk; // error may be raised
    logic onCust; // customer prefix match
    logic onOp; // operator prefix match
    logic expired; // hop limit used up
    // neighbor cache, learns from parsed adverts
    nbr_cache #(
        .ENTRIES(CACHE_ENTRIES)
    ) u_cache (
        .mclk(mclk),
        .reset(reset),
        .lookIp(st.nh),
        .lookHit(cacheHit),
        .lookMac(cacheMac),
        .wrEn(naValid),
        .wrIp(naTarget),
        .wrMac(naMac)
    );

    // classification of the held header
    assign isMc = st.dst[127:120] == fwd_pkg::MCAST_TOP;
    assign isLlMc = st.dst[127:112] == fwd_pkg::LL_MCAST;
    assign isOwn = st.dst == opIp || st.dst == custIp;
    // types below 128 are errors, never answered
    assign isIcmpErr = st.nxt == fwd_pkg::NH_ICMPV6 && st.icmp < fwd_pkg::ICMP_INFO_MIN;
    // unspecified or multicast source names nobody
    assign srcOk = st.src != '0 && st.src[127:120] != fwd_pkg::MCAST_TOP;
    // silence icmp for the exception cases
    assign errOk = !st.congested && !isIcmpErr && !st.l2Mcast && srcOk && !isMc;
    assign onCust = st.dst[127:64] == custPrefix;
    assign onOp = st.dst[127:64] == opPrefix || (st.lpValid && st.dst[127:64] == st.lpPrefix);
    // zero on arrival or zero after decrement
    assign expired = st.hop <= fwd_pkg::HOP_LAST;
    // next state of the whole engine
    always_comb begin
        next_st = st;
        next_st.resValid = 1'b0;
        next_st.errValid = 1'b0;
        next_st.ndValid = 1'b0;
        // routing table grows from operator side adverts
        if (raValid && raPort == fwd_pkg::PORT_OP) begin
            next_st.drValid = 1'b1;
            next_st.drAddr = raRouter;
            if (raPrefixValid) begin
                next_st.lpValid = 1'b1;
                next_st.lpPrefix = raPrefix;
            end
        end
        case (st.state)
            fwd_pkg::ST_IDLE: begin
                // hold exactly one header at a time
                if (pktValid) begin
                    next_st.port = pktPort;
                    next_st.src = pktSrc;
                    next_st.dst = pktDst;
                    next_st.hop = pktHop;
                    next_st.nxt = pktNext;
                    next_st.icmp = pktIcmp;
                    next_st.l2Mcast = pktL2Mcast;
                    next_st.congested = pktCongested;
                    next_st.state = fwd_pkg::ST_DECIDE;
                end
            end
            fwd_pkg::ST_DECIDE: begin
                next_st.state = fwd_pkg::ST_IDLE;
                next_st.resPort = st.port;
                next_st.resDstMac = '0;
                next_st.resSrcMac = '0;
                next_st.resHop = st.hop;
                next_st.errPort = st.port;
                if (st.congested) begin
                    // congestion drop, never reported
                    next_st.resValid = 1'b1;
                    next_st.resAction = fwd_pkg::ACT_DROP;
                end else if (isOwn || isMc) begin
                    // own traffic, nd, listener and link local
                    // multicast stay on the local stack
                    next_st.resValid = 1'b1;
                    next_st.resAction = fwd_pkg::ACT_LOCAL;
                end else if (expired) begin
                    next_st.resValid = 1'b1;
                    next_st.resAction = fwd_pkg::ACT_DROP;
                    next_st.errValid = errOk;
                    next_st.errType = fwd_pkg::ICMP_TIME_EXCEEDED;
                    next_st.errCode = fwd_pkg::CODE_HOP_EXCEEDED;
                end else if (onCust) begin
                    next_st.nh = st.dst;
                    next_st.nhPort = fwd_pkg::PORT_CUST;
                    next_st.state = fwd_pkg::ST_RESOLVE;
                end else if (onOp) begin
                    next_st.nh = st.dst;
                    next_st.nhPort = fwd_pkg::PORT_OP;
                    next_st.state = fwd_pkg::ST_RESOLVE;
                end else if (st.drValid) begin
                    // remote: resolve the router, not the host
                    next_st.nh = st.drAddr;
                    next_st.nhPort = fwd_pkg::PORT_OP;
                    next_st.state = fwd_pkg::ST_RESOLVE;
                end else begin
                    // no router: drop now, nothing queued
                    next_st.resValid = 1'b1;
                    next_st.resAction = fwd_pkg::ACT_DROP;
                    // an unreachable may not leave the operator side
                    next_st.errValid = errOk && st.port == fwd_pkg::PORT_CUST;
                    next_st.errType = fwd_pkg::ICMP_DEST_UNREACH;
                    next_st.errCode = fwd_pkg::CODE_NO_ROUTE;
                end
            end
            fwd_pkg::ST_RESOLVE, fwd_pkg::ST_WAIT: begin
                if (cacheHit) begin
                    // rebuild the ethernet header and send
                    next_st.resValid = 1'b1;
                    next_st.resAction = fwd_pkg::ACT_FORWARD;
                    next_st.resPort = st.nhPort;
                    next_st.resDstMac = cacheMac;
                    next_st.resSrcMac = st.nhPort == fwd_pkg::PORT_OP ? opMac : custMac;
                    next_st.resHop = st.hop - fwd_pkg::HOP_LAST;
                    next_st.state = fwd_pkg::ST_IDLE;
                end else if (st.state == fwd_pkg::ST_RESOLVE) begin
                    // miss: multicast a solicitation, then wait
                    next_st.ndValid = 1'b1;
                    next_st.ndType = fwd_pkg::ICMP_NBR_SOLICIT;
                    next_st.ndPort = st.nhPort;
                    next_st.ndTarget = st.nh;
                    next_st.timer = '0;
                    next_st.state = fwd_pkg::ST_WAIT;
                end else if (st.timer == RESOLVE_LAST) begin
                    // no advert in time: give up on the packet
                    next_st.resValid = 1'b1;
                    next_st.resAction = fwd_pkg::ACT_DROP;
                    next_st.errValid = errOk && st.port == fwd_pkg::PORT_CUST;
                    next_st.errType = fwd_pkg::ICMP_DEST_UNREACH;
                    next_st.errCode = fwd_pkg::CODE_ADDR_UNREACH;
                    next_st.state = fwd_pkg::ST_IDLE;
                end else begin
                    next_st.timer = st.timer + 1'b1;
                end
            end
            default: begin
                next_st.state = fwd_pkg::ST_IDLE;
            end
        endcase
        // advert period saturates until the slot is free
        if (st.raTimer != RA_LAST) begin
            next_st.raTimer = st.raTimer + 1'b1;
        end
        // solicitations win; adverts and the start-up
        // router solicitation use the spare nd slot.
        // only nd is originated, no routing protocol.
        if (!next_st.ndValid) begin
            if (st.raTimer == RA_LAST) begin
                next_st.ndValid = 1'b1;
                next_st.ndType = fwd_pkg::ICMP_RTR_ADVERT;
                next_st.ndPort = fwd_pkg::PORT_CUST;
                next_st.ndTarget = fwd_pkg::ALL_NODES;
                next_st.raTimer = '0;
            end else if (!st.rsDone) begin
                next_st.ndValid = 1'b1;
                next_st.ndType = fwd_pkg::ICMP_RTR_SOLICIT;
                next_st.ndPort = fwd_pkg::PORT_OP;
                next_st.ndTarget = fwd_pkg::ALL_ROUTERS;
                next_st.rsDone = 1'b1;
            end
        end
    end
    // state register; reset empties the routing table
    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // outputs come straight from the state register
    assign pktReady = st.state == fwd_pkg::ST_IDLE;
    assign resValid = st.resValid;
    assign resAction = st.resAction;
    assign resPort = st.resPort;
    assign resDstMac = st.resDstMac;
    assign resSrcMac = st.resSrcMac;
    assign resHop = st.resHop;
    assign errValid = st.errValid;
    assign errType = st.errType;
    assign errCode = st.errCode;
    assign errPort = st.errPort;
    assign ndValid = st.ndValid;
    assign ndType = st.ndType;
    assign ndPort = st.ndPort;
    assign ndTarget = st.ndTarget;
    // checks on the decision engine
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    own_local_a: assert property (
        st.state == fwd_pkg::ST_DECIDE && !st.congested && (st.dst == custIp || st.dst == opIp)
        |=> resValid && resAction == fwd_pkg::ACT_LOCAL)
        else $error("own address not delivered locally");
    link_local_a: assert property (
        st.state == fwd_pkg::ST_DECIDE && isLlMc
        |=> resValid && resAction != fwd_pkg::ACT_FORWARD)
        else $error("link local multicast forwarded");
    onlink_nh_a: assert property (
        st.state == fwd_pkg::ST_DECIDE && !st.congested && !isOwn && !isMc && !expired && onCust
        |=> st.nh == $past(st.dst) && st.state == fwd_pkg::ST_RESOLVE)
        else $error("on-link next hop is not the destination");
    // idle in the drop cycle: a packet taken right away is legal
    no_router_a: assert property (
        st.state == fwd_pkg::ST_DECIDE && !st.congested && !isOwn && !isMc && !expired
        && !onCust && !onOp && !st.drValid
        |=> resValid && resAction == fwd_pkg::ACT_DROP && pktReady)
        else $error("packet without router not dropped at once");
    miss_solicit_a: assert property (
        st.state == fwd_pkg::ST_RESOLVE && !cacheHit
        |=> ndValid && ndType == fwd_pkg::ICMP_NBR_SOLICIT && ndTarget == $past(st.nh))
        else $error("cache miss sent no solicitation");
    hop_decrement_a: assert property (
        resValid && resAction == fwd_pkg::ACT_FORWARD
        |-> resHop == st.hop - 8'h01 && resHop != 8'h00)
        else $error("forwarded hop limit wrong");
    expire_error_a: assert property (
        st.state == fwd_pkg::ST_DECIDE && !st.congested && !isOwn && !isMc && expired && errOk
        |=> errValid && errType == fwd_pkg::ICMP_TIME_EXCEEDED && errCode == 8'h00)
        else $error("expired hop limit not reported");
    src_mac_a: assert property (
        resValid && resAction == fwd_pkg::ACT_FORWARD
        |-> resSrcMac == (resPort == fwd_pkg::PORT_OP ? opMac : custMac))
        else $error("wrong ethernet source mac");
    err_silence_a: assert property (
        errValid |-> !st.congested && !st.l2Mcast && !isIcmpErr && !isMc)
        else $error("error raised for an excepted packet");
    no_unreach_op_a: assert property (
        errValid && errType == fwd_pkg::ICMP_DEST_UNREACH |-> errPort == fwd_pkg::PORT_CUST)
        else $error("unreachable sent out the operator side");
    ra_cust_only_a: assert property (
        ndValid && ndType == fwd_pkg::ICMP_RTR_ADVERT |-> ndPort == fwd_pkg::PORT_CUST)
        else $error("router advert on operator side");
    wait_bound_a: assert property (
        st.state == fwd_pkg::ST_WAIT && st.timer == RESOLVE_LAST && !cacheHit
        |=> resValid && resAction == fwd_pkg::ACT_DROP && st.state == fwd_pkg::ST_IDLE)
        else $error("resolution wait overran");
endmodule

// ### include/fwd_pkg.sv
// Purpose: shared constants for the ipv6 forwarding engine
// Assumes: 20 MHz mclk, header fields parsed upstream
// Notes: icmpv6 type codes and timing counts live here
package fwd_pkg;
    // decision engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DECIDE = 2'b01,
        ST_RESOLVE = 2'b10,
        ST_WAIT = 2'b11
    } state_e;
    // what happens to a packet
    localparam logic [1:0] ACT_LOCAL = 2'h0;
    localparam logic [1:0] ACT_FORWARD = 2'h1;
    localparam logic [1:0] ACT_DROP = 2'h2;
    // interface select
    localparam logic PORT_OP = 1'b0;
    localparam logic PORT_CUST = 1'b1;
    // icmpv6 types
    localparam logic [7:0] ICMP_DEST_UNREACH = 8'h01;
    localparam logic [7:0] ICMP_TIME_EXCEEDED = 8'h03;
    localparam logic [7:0] ICMP_INFO_MIN = 8'h80;
    localparam logic [7:0] ICMP_ECHO_REPLY = 8'h81;
    localparam logic [7:0] ICMP_MLD_QUERY = 8'h82;
    localparam logic [7:0] ICMP_MLD_REPORT = 8'h83;
    localparam logic [7:0] ICMP_MLD_DONE = 8'h84;
    localparam logic [7:0] ICMP_RTR_SOLICIT = 8'h85;
    localparam logic [7:0] ICMP_RTR_ADVERT = 8'h86;
    localparam logic [7:0] ICMP_NBR_SOLICIT = 8'h87;
    localparam logic [7:0] ICMP_NBR_ADVERT = 8'h88;
    localparam logic [7:0] ICMP_MLD2_REPORT = 8'h8f;
    // icmpv6 codes
    localparam logic [7:0] CODE_NO_ROUTE = 8'h00;
    localparam logic [7:0] CODE_ADDR_UNREACH = 8'h03;
    localparam logic [7:0] CODE_HOP_EXCEEDED = 8'h00;
    // header values
    localparam logic [7:0] NH_ICMPV6 = 8'h3a;
    localparam logic [7:0] MCAST_TOP = 8'hff;
    localparam logic [15:0] LL_MCAST = 16'hff02;
    localparam logic [7:0] HOP_LAST = 8'h01;
    localparam logic [127:0] ALL_NODES = 128'hff02_0000_0000_0000_0000_0000_0000_0001;
    localparam logic [127:0] ALL_ROUTERS = 128'hff02_0000_0000_0000_0000_0000_0000_0002;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int RESOLVE_TIME_MS = 1000;
    localparam int RA_TIME_MS = 4000;
    localparam int RESOLVE_CYCLES = RESOLVE_TIME_MS * (CLK_HZ / 1000);
    localparam int RA_CYCLES = RA_TIME_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 28;
    localparam int CACHE_ENTRIES = 8;
endpackage

// ### src/nbr_cache.sv
// Purpose: neighbor cache, ipv6 address to mac
// Assumes: one learn and one lookup per cycle
// Notes: round robin replacement, no aging
`timescale 1ns/100ps
module nbr_cache #(
    parameter int ENTRIES = fwd_pkg::CACHE_ENTRIES
) (
    input wire logic mclk, // 20 MHz clock
    input wire logic reset, // sync, active high
    input wire logic [127:0] lookIp, // address to resolve
    output logic lookHit, // entry found
    output logic [47:0] lookMac, // mac of the entry
    input wire logic wrEn, // learn strobe
    input wire logic [127:0] wrIp, // learned address
    input wire logic [47:0] wrMac // learned mac
);
    localparam int IDX_W = $clog2(ENTRIES);
    // entry count must index cleanly
    if (ENTRIES < 2 || (1 << IDX_W) != ENTRIES) begin : g_bad
        $error("nbr_cache: ENTRIES must be a power of two >= 2");
    end
    typedef struct packed {
        logic [ENTRIES-1:0] valid; // entry in use
        logic [ENTRIES-1:0][127:0] ip; // keys
        logic [ENTRIES-1:0][47:0] mac; // values
        logic [IDX_W-1:0] victim; // next slot to replace
    } cache_s;
    cache_s st;
    cache_s next_st;
    logic [ENTRIES-1:0] lookMatch; // per entry hit
    logic [ENTRIES-1:0] wrMatch; // entry already known
    // compare every entry in parallel
    for (genvar i = 0; i < ENTRIES; i++) begin : g_cmp
        assign lookMatch[i] = st.valid[i] && st.ip[i] == lookIp;
        assign wrMatch[i] = st.valid[i] && st.ip[i] == wrIp;
    end
    // refresh in place, else take the victim slot
    always_comb begin
        next_st = st;
        lookHit = |lookMatch;
        lookMac = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (lookMatch[i]) begin
                lookMac = st.mac[i];
            end
        end
        if (wrEn && |wrMatch) begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (wrMatch[i]) begin
                    next_st.mac[i] = wrMac;
                end
            end
        end else if (wrEn) begin
            next_st.valid[st.victim] = 1'b1;
            next_st.ip[st.victim] = wrIp;
            next_st.mac[st.victim] = wrMac;
            next_st.victim = st.victim + 1'b1;
        end
    end
    // state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ### tb/nbr_model.sv
// Purpose: neighbour model, answers each solicitation with an advert
// Assumes: solicitation seen as an nd strobe with type 0x87
// Notes: fixed latency, mac built from low target bits, low byte ff is absent
`timescale 1ns/100ps
module nbr_model #(
    parameter int DELAY = 3 // cycles until the advert
) (
    input wire logic mclk, // bench clock
    input wire logic ndValid, // nd strobe from the block
    input wire logic [7:0] ndType, // nd message type
    input wire logic [127:0] ndTarget, // solicited address
    output logic naValid = 1'b0, // advert strobe
    output logic [127:0] naTarget = '0, // advertised address
    output logic [47:0] naMac = '0 // advertised mac
);
    int cnt = 0; // answer countdown, 0 idle
    logic [127:0] held = '0; // address being resolved
    // answer off the sampling edge; target is scrambled outside the strobe
    // an absent host never answers, so the block must time out
    always @(negedge mclk) begin
        if (cnt == 1) begin
            naValid <= 1'b1;
            naTarget <= held;
            naMac <= {16'h0200, held[31:0]};
        end else begin
            naValid <= 1'b0;
            naTarget <= ~held;
        end
        if (ndValid === 1'b1 && ndType === fwd_pkg::ICMP_NBR_SOLICIT && ndTarget[7:0] !== 8'hff) begin
            held <= ndTarget;
            cnt <= DELAY;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ### tb/ipv6_fwd_tb.sv
// Purpose: self-checking bench for the forwarding engine
// Assumes: neighbour model answers every solicitation but low byte ff
// Notes: short resolve and advert periods keep the run brief
`timescale 1ns/100ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errorCnt++; $display("[ERR] %0t %h %h", $time, a, b); end end
module ipv6_fwd_tb;
    localparam logic [63:0] CUX = 64'h2001_0db8_0000_0002; // customer prefix
    localparam logic [127:0] RTR = {64'hfe80_0000_0000_0000, 64'h1}; // upstream router
    localparam logic [127:0] FAR = {64'h2001_0db8_0000_0009, 64'h5}; // off-link host
    logic mclk = 0, reset = 1, pktValid = 0, pktPort = 0, pktCongested = 0, pktL2Mcast = 0; // stimulus
    logic raValid = 0, raPort = 0, raPrefixValid = 0; // router advert input
    logic [127:0] pktDst = '0, raRouter = RTR, pktSrc = {CUX, 64'h9}; // addresses
    logic [127:0] opIp = {64'h2001_0db8_0000_0001, 64'h1}, custIp = {CUX, 64'h1}; // own addresses
    logic [63:0] opPrefix = 64'h2001_0db8_0000_0001, custPrefix = CUX, raPrefix = '0; // prefixes
    logic [47:0] opMac = 48'h0200_0000_00a1, custMac = 48'h0200_0000_00b2; // interface macs
    logic [7:0] pktHop = 8'h40, pktNext = 8'h11, pktIcmp = 8'h80; // header fields
    logic naValid, resValid, pktReady, errValid, ndValid, resPort, errPort, ndPort; // strobes
    logic [1:0] resAction; // decision
    logic [7:0] resHop, errType, errCode, ndType; // result fields
    logic [47:0] resDstMac, resSrcMac, naMac; // macs
    logic [127:0] naTarget, ndTarget; // targets
    int errorCnt = 0, nChecks = 0; // tallies
    ipv6_fwd #(.RESOLVE_CYCLES(16), .RA_CYCLES(64)) i_ipv6_fwd (.mclk, .reset, .opIp, .custIp, .opPrefix,
        .custPrefix, .opMac, .custMac, .pktValid, .pktReady, .pktPort, .pktSrc, .pktDst, .pktHop, .pktNext,
        .pktIcmp, .pktL2Mcast, .pktCongested, .naValid, .naTarget, .naMac, .raValid, .raPort, .raRouter,
        .raPrefixValid, .raPrefix, .resValid, .resAction, .resPort, .resDstMac, .resSrcMac, .resHop,
        .errValid, .errType, .errCode, .errPort, .ndValid, .ndType, .ndPort, .ndTarget);
    nbr_model i_nbr_model (.mclk, .ndValid, .ndType, .ndTarget, .naValid, .naTarget, .naMac);
    // 50 ns period
    initial forever #25 mclk = ~mclk;
    task automatic finishTest;
        if (errorCnt == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // wait for a result (nd low) or an nd strobe (nd high), bounded; a miss ends the run
    task automatic waitFor(input logic nd, input int lim);
        int n = 0;
        while ((nd ? ndValid : resValid) !== 1'b1 && n < lim) begin
            @(negedge mclk);
            n++;
        end
        if ((nd ? ndValid : resValid) !== 1'b1) begin
            errorCnt++;
            finishTest();
        end
    endtask
    // offer one header; returns in the cycle of the decision
    task automatic pkt(input logic p, input logic [127:0] d, input logic [7:0] h, input logic c);
        @(negedge mclk);
        pktPort = p;
        pktDst = d;
        pktHop = h;
        pktCongested = c;
        pktValid = 1'b1;
        @(negedge mclk);
        pktValid = 1'b0;
        waitFor(1'b0, 99);
    endtask
    task automatic tStart; // router solicitation after reset
        repeat (16) @(negedge mclk);
        reset = 0;
        waitFor(1'b1, 8);
        `CHK(ndType, fwd_pkg::ICMP_RTR_SOLICIT)
        `CHK(ndPort, fwd_pkg::PORT_OP)
        `CHK(ndTarget, fwd_pkg::ALL_ROUTERS)
    endtask
    task automatic tLocal; // own address and link-local group
        pkt(1'b1, opIp, 8'h40, 1'b0);
        `CHK(resAction, fwd_pkg::ACT_LOCAL)
        pkt(1'b0, fwd_pkg::ALL_NODES, 8'h40, 1'b0);
        `CHK(resAction, fwd_pkg::ACT_LOCAL)
    endtask
    task automatic tNoRoute; // remote with no router known
        pkt(1'b1, FAR, 8'h40, 1'b0);
        `CHK(resAction, fwd_pkg::ACT_DROP)
        `CHK(errValid, 1'b1)
        `CHK(errType, fwd_pkg::ICMP_DEST_UNREACH)
        `CHK(errCode, 8'h00)
        `CHK(errPort, fwd_pkg::PORT_CUST)
        `CHK(pktReady, 1'b1)
        pkt(1'b0, FAR, 8'h40, 1'b0);
        `CHK(errValid, 1'b0)
    endtask
    task automatic tHop; // last hop, then congestion
        pkt(1'b1, {CUX, 64'h7}, 8'h01, 1'b0);
        `CHK(errType, fwd_pkg::ICMP_TIME_EXCEEDED)
        `CHK(errCode, 8'h00)
        `CHK(errValid, 1'b1)
        `CHK(resAction, fwd_pkg::ACT_DROP)
        pktL2Mcast = 1'b1;
        pkt(1'b1, {CUX, 64'h7}, 8'h01, 1'b0);
        `CHK(errValid, 1'b0)
        pktL2Mcast = 1'b0;
        pkt(1'b1, {CUX, 64'h7}, 8'h40, 1'b1);
        `CHK(errValid, 1'b0)
    endtask
    task automatic tOnLink; // operator to customer host
        pkt(1'b0, {CUX, 64'h7}, 8'h40, 1'b0);
        `CHK(resAction, fwd_pkg::ACT_FORWARD)
        `CHK(resSrcMac, custMac)
        `CHK(resDstMac, 48'h0200_0000_0007)
        `CHK(resHop, 8'h3f)
    endtask
    task automatic tRemote; // learn router, forward upstream
        @(negedge mclk);
        raValid = 1'b1;
        @(negedge mclk);
        raValid = 1'b0;
        pkt(1'b1, FAR, 8'h40, 1'b0);
        `CHK(resPort, fwd_pkg::PORT_OP)
        `CHK(resSrcMac, opMac)
        `CHK(resDstMac, 48'h0200_0000_0001)
    endtask
    task automatic tAdvert; // periodic router advert side
        int n = 0;
        while (!(ndValid === 1'b1 && ndType === fwd_pkg::ICMP_RTR_ADVERT) && n < 80) begin
            @(negedge mclk);
            n++;
        end
        `CHK(ndValid === 1'b1 && ndType === fwd_pkg::ICMP_RTR_ADVERT, 1'b1)
        `CHK(ndPort, fwd_pkg::PORT_CUST)
        `CHK(ndTarget, fwd_pkg::ALL_NODES)
    endtask
    task automatic tTimeout; // absent host, resolution gives up
        pkt(1'b1, {CUX, 64'hff}, 8'h40, 1'b0);
        `CHK(resAction, fwd_pkg::ACT_DROP)
        `CHK(errValid, 1'b1)
        `CHK(errCode, 8'h03)
    endtask
    initial begin
        tStart();
        tLocal();
        tNoRoute();
        tHop();
        tOnLink();
        tRemote();
        tAdvert();
        tTimeout();
        finishTest();
    end
endmodule
